/* File: dv/sees_spi_master.sv */
`timescale 1ns/1ps
`default_nettype none
module sees_spi_master (
  // Clock
  input wire logic clk_i,
  // Serial pins
  input wire logic so_wire_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o,
  output logic hold_n_o
);
  int hold_k = -1;
  logic cpol = 1'b0;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
    hold_n_o = 1'b1;
  end
  // Six clk per half period keeps each level visible through the pin synchroniser
  task automatic frame(input logic [7:0] b [6], input int n, output logic [7:0] rx);
    @(negedge clk_i);
    sck_o = cpol;
    repeat (6) @(negedge clk_i);
    cs_n_o = 1'b0;
    repeat (6) @(negedge clk_i);
    for (int k = 0; k < n * 8; k++) begin
      sck_o = 1'b0;
      si_o = b[k / 8][7 - k % 8];
      // Hold moves mid-way through the low phase, never beside a clock edge
      if (k == hold_k) begin
        repeat (6) @(negedge clk_i);
        hold_n_o = 1'b0;
        repeat (20) @(negedge clk_i);
        hold_n_o = 1'b1;
      end
      repeat (6) @(negedge clk_i);
      sck_o = 1'b1;
      rx = {rx[6:0], so_wire_i};
      repeat (6) @(negedge clk_i);
    end
    sck_o = cpol;
    repeat (6) @(negedge clk_i);
    cs_n_o = 1'b1;
    si_o = ~si_o;
    repeat (6) @(negedge clk_i);
  endtask : frame
endmodule : sees_spi_master
`default_nettype wire

/* File: dv/sees_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
module sees_top_props #(
  parameter int unsigned WRITE_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Serial pins
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic so_o,
  input wire logic so_oe_n_o,
  // Control and status
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  input wire logic standby_o
);
  logic sck_q;
  logic sck_fall;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= sck_i;
    end
  end
  assign sck_fall = sck_q & ~sck_i;
  float_deselect_a: assert property (cs_n_i [*4] |-> so_oe_n_o)
    else $error("output driven while deselected");
  hold_float_a: assert property (!hold_n_i [*4] |-> so_oe_n_o)
    else $error("output driven during hold");
  select_busy_a: assert property (!cs_n_i [*4] |-> !standby_o)
    else $error("standby while selected");
  drive_cause_a: assert property ($fell(so_oe_n_o) |-> !$past(cs_n_i, 2) && $past(hold_n_i, 2))
    else $error("output enabled without selection");
  shift_on_fall_a: assert property ($changed(so_o) && !cs_n_i && !so_oe_n_o && !$past(so_oe_n_o)
    |-> $past(sck_fall, 2) || $past(sck_fall, 3) || $past(sck_fall, 4))
    else $error("output bit moved without falling clock");
  reset_standby_a: assert property ($fell(reset_i) |-> standby_o && so_oe_n_o)
    else $error("not in standby after reset");
  write_ends_a: assert property (cs_n_i [*4] ##0 !standby_o |-> ##[1:1000] standby_o)
    else $error("write cycle does not end");
  standby_kept_a: assert property (cs_n_i [*4] ##0 standby_o |=> standby_o)
    else $error("standby left while deselected");
endmodule : sees_top_props
bind sees_top sees_top_props #(.WRITE_CYCLES(WRITE_CYCLES)) sees_top_props_i (.clk_i(clk_i), .reset_i(reset_i),
  .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o), .hold_n_i(hold_n_i),
  .wp_n_i(wp_n_i), .standby_o(standby_o));
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sees_pkg::*;
  typedef struct {logic [7:0] wop; logic [7:0] rop; logic [7:0] addr; logic [7:0] data;} sees_row_t;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic wp_n_i = 1'b1;
  logic cs_n, sck, si, hold_n, so_o, so_oe_n_o, standby_o;
  logic [7:0] rx;
  int mismatches = 0;
  int samples_checked = 0;
  sees_row_t rows [4] = '{'{OP_WRITE, OP_READ, 8'h00, 8'ha5}, '{OP_WRITE, OP_READ, 8'hff, 8'h5a},
    '{OP_WRITE, OP_READ, 8'hc0, 8'h11}, '{OP_IDWR, OP_IDRD, 8'h03, 8'h3c}};
  wire so_wire = so_oe_n_o ? 1'bz : so_o;
  always #2.5 clk_i = ~clk_i;
  sees_top #(.WRITE_CYCLES(400)) sees_top_i (.clk_i(clk_i), .reset_i(reset_i), .cs_n_i(cs_n), .sck_i(sck),
    .si_i(si), .so_o(so_o), .so_oe_n_o(so_oe_n_o), .hold_n_i(hold_n), .wp_n_i(wp_n_i), .standby_o(standby_o));
  sees_spi_master sees_spi_master_i (.clk_i(clk_i), .so_wire_i(so_wire), .cs_n_o(cs_n), .sck_o(sck),
    .si_o(si), .hold_n_o(hold_n));
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp8
  task automatic send(input logic [7:0] b0, b1, b2, b3, b4, input int n);
    sees_spi_master_i.frame('{b0, b1, b2, b3, b4, 8'h00}, n, rx);
  endtask : send
  // Standby returns only after the synchroniser delay, so look late
  task automatic wait_idle();
    int i;
    i = 0;
    repeat (8) @(negedge clk_i);
    while (standby_o !== 1'b1 && i < 1000) begin
      @(negedge clk_i);
      i++;
    end
    if (i == 1000) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : wait_idle
  task automatic wr(input logic [7:0] op, a, d, input int n);
    send(OP_WREN, 8'h00, 8'h00, 8'h00, 8'h00, 1);
    send(op, a, d, 8'h00, 8'h00, n);
    wait_idle();
  endtask : wr
  task automatic rd(input logic [7:0] op, a, exp);
    send(op, a, 8'h00, 8'h00, 8'h00, 3);
    cmp8("read", exp, rx);
  endtask : rd
  initial begin
    repeat (16) @(negedge clk_i);
    reset_i = 1'b0;
    cmp8("standby", 8'h01, {7'h00, standby_o});
    cmp8("oe_n", 8'h01, {7'h00, so_oe_n_o});
    repeat (3) @(negedge clk_i);
    foreach (rows[r]) begin
      wr(rows[r].wop, rows[r].addr, rows[r].data, 3);
      rd(rows[r].rop, rows[r].addr, rows[r].data);
    end
    send(OP_WREN, 8'h00, 8'h00, 8'h00, 8'h00, 1);
    send(OP_WRITE, 8'h2e, 8'h01, 8'h02, 8'h03, 5);
    repeat (6) @(negedge clk_i);
    cmp8("standby", 8'h00, {7'h00, standby_o});
    send(OP_RDSR, 8'h00, 8'h00, 8'h00, 8'h00, 2);
    cmp8("busy status", SR_BUSY_VAL, rx);
    wait_idle();
    rd(OP_READ, 8'h20, 8'h03);
    sees_spi_master_i.hold_k = 20;
    rd(OP_READ, 8'h2f, 8'h02);
    sees_spi_master_i.hold_k = -1;
    sees_spi_master_i.cpol = 1'b1;
    rd(OP_READ, 8'h2e, 8'h01);
    sees_spi_master_i.cpol = 1'b0;
    wr(OP_WRSR, 8'h04, 8'h00, 2);
    send(OP_RDSR, 8'h00, 8'h00, 8'h00, 8'h00, 2);
    cmp8("status", 8'h04, rx);
    wr(OP_WRSR, 8'h84, 8'h00, 2);
    wp_n_i = 1'b0;
    wr(OP_WRSR, 8'h00, 8'h00, 2);
    send(OP_RDSR, 8'h00, 8'h00, 8'h00, 8'h00, 2);
    cmp8("status", 8'h86, rx);
    wp_n_i = 1'b1;
    wr(OP_WRITE, 8'hc0, 8'h22, 3);
    rd(OP_READ, 8'hc0, 8'h11);
    wr(OP_IDLK, 8'h00, 8'h00, 1);
    wr(OP_IDWR, 8'h03, 8'h77, 3);
    rd(OP_IDRD, 8'h03, 8'h3c);
    // A frame sent while reset is high must leave no trace
    reset_i = 1'b1;
    send(OP_WREN, 8'h00, 8'h00, 8'h00, 8'h00, 1);
    reset_i = 1'b0;
    cmp8("standby", 8'h01, {7'h00, standby_o});
    repeat (3) @(negedge clk_i);
    send(OP_RDSR, 8'h00, 8'h00, 8'h00, 8'h00, 2);
    cmp8("status", 8'h00, rx);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire

/* File: pkg/sees_pkg.sv */
package sees_pkg;
  // Geometry
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned MEM_BYTES = 256;
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned COL_W = 4;
  localparam int unsigned BUF_DEPTH = 2;

  // Instruction codes
  localparam logic [7:0] OP_NONE = 8'h00;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_IDWR = 8'h82;
  localparam logic [7:0] OP_IDRD = 8'h83;
  localparam logic [7:0] OP_IDLK = 8'h8b;

  // Status byte layout
  localparam int unsigned SR_BUSY_BIT = 0;
  localparam int unsigned SR_WEN_BIT = 1;
  localparam int unsigned SR_BP0_BIT = 2;
  localparam int unsigned SR_BP1_BIT = 3;
  localparam int unsigned SR_ARM_BIT = 7;
  localparam logic [7:0] SR_BUSY_VAL = 8'hff;

  // Reset values
  localparam logic [1:0] BP_RST = 2'h0;
  localparam logic ARM_RST = 1'b0;
  localparam logic WEN_RST = 1'b0;
  localparam logic LOCK_RST = 1'b0;
  localparam logic [7:0] SO_IDLE_VAL = 8'h00;

  // Lowest protected address per level
  localparam logic [7:0] PROT_Q_BASE = 8'hc0;
  localparam logic [7:0] PROT_H_BASE = 8'h80;

  // Self-timed write, longest time rounds down
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned T_WRITE_NS = 4000000;
  localparam int unsigned WRITE_CYCLES_DEF = T_WRITE_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CMD = 3'h1,
    ST_ADDR = 3'h2,
    ST_WDATA = 3'h3,
    ST_RDATA = 3'h4,
    ST_WSR = 3'h5,
    ST_SKIP = 3'h6
  } sees_state_t;
endpackage : sees_pkg

/* File: pkg/sees_strm_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sees_strm_if;
  import sees_pkg::*;
  logic valid;
  logic ready;
  logic [BYTE_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sees_strm_if
`default_nettype wire

/* File: verilog/sees_buf2.sv */
`timescale 1ns/1ps
`default_nettype none
module sees_buf2 import sees_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Streams
  sees_strm_if.snk in_s,
  sees_strm_if.src out_s
);
  logic [BYTE_W-1:0] slot_q [BUF_DEPTH];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign in_s.ready = (cnt_q != 2'(BUF_DEPTH));
  assign out_s.valid = (cnt_q != 2'h0);
  assign out_s.data = slot_q[rd_ptr_q];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wr_ptr_q <= ~wr_ptr_q;
      if (pop) rd_ptr_q <= ~rd_ptr_q;
      if (push && !pop) cnt_q <= cnt_q + 2'h1;
      else if (pop && !push) cnt_q <= cnt_q - 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) slot_q[wr_ptr_q] <= in_s.data;
  end
endmodule : sees_buf2
`default_nettype wire

/* File: verilog/sees_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Modes 0 and 3; capture on rising edge
// - 256 bytes, programmed in 16-byte pages
// - Byte and partial page writes accepted
// - Self-timed write, at most 4 ms
// - Protect upper quarter, half or whole array
// - Ignore everything until power-on reset releases
// - Standby after transaction, after any write
// - Extra 16-byte page, lockable until power-on reset
// - First byte after select is instruction
// - All bytes travel most significant first
// - Output floats while deselected or idle
// - Sample on rising, shift out on falling
// - Hold pauses sequence, resume same point
// - Pin protection needs pin low, arm set
module sees_top import sees_pkg::*; #(
  parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DEF
) (
  // Clock and power-on reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Serial pins
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_n_o,
  // Control pins
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  // Status
  output logic standby_o
);
  localparam int unsigned BUSY_W = $clog2(WRITE_CYCLES + 1);

  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic cs_prev_q;
  logic sck_prev_q;
  logic cs_n_s, sck_s, si_s, hold_n_s, wp_n_s;
  logic live, sck_rise, sck_fall, cs_fall, cs_rise, byte_done;
  logic [BYTE_W-1:0] rx_byte;

  sees_state_t state_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] rx_q;
  logic [7:0] op_q;
  logic [7:0] addr_q;
  logic [7:0] tx_q;
  logic so_q;
  logic so_en_q;
  logic [7:0] sr_new_q;
  logic sr_got_q;

  logic [7:0] mem_q [MEM_BYTES];
  logic [7:0] idp_q [PAGE_BYTES];
  logic [7:0] pl_data_q [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pl_mask_q;
  logic [COL_W-1:0] col_q;
  logic [3:0] page_q;

  logic wen_q, arm_q, lock_q, busy_q, commit_pend_q;
  logic [1:0] bp_q;
  logic [BUSY_W-1:0] busy_cnt_q;
  logic hw_prot, commit_go, sr_go, lk_go, busy_start;
  logic [7:0] status;

  sees_strm_if in_if ();
  sees_strm_if out_if ();

  function automatic logic blk_prot(input logic [7:0] a, input logic [1:0] bp);
    unique case (bp)
      2'b00: blk_prot = 1'b0;
      2'b01: blk_prot = (a >= PROT_Q_BASE);
      2'b10: blk_prot = (a >= PROT_H_BASE);
      2'b11: blk_prot = 1'b1;
    endcase
  endfunction : blk_prot

  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == OP_READ) || (op == OP_IDRD);
  endfunction : is_read

  // Pins come from the master's domain
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_q <= 5'h1d;
      sync2_q <= 5'h1d;
      cs_prev_q <= 1'b1;
      sck_prev_q <= 1'b0;
    end else begin
      sync1_q <= {wp_n_i, hold_n_i, si_i, sck_i, cs_n_i};
      sync2_q <= sync1_q;
      cs_prev_q <= cs_n_s;
      sck_prev_q <= sck_s;
    end
  end
  assign {wp_n_s, hold_n_s, si_s, sck_s, cs_n_s} = sync2_q;

  // Hold freezes the sequence by hiding clock edges
  assign live = !cs_n_s && hold_n_s;
  assign sck_rise = live && sck_s && !sck_prev_q;
  assign sck_fall = live && !sck_s && sck_prev_q;
  assign cs_fall = cs_prev_q && !cs_n_s;
  assign cs_rise = !cs_prev_q && cs_n_s;
  assign rx_byte = {rx_q, si_s};
  assign byte_done = sck_rise && (bit_cnt_q == 3'h7);
  assign hw_prot = !wp_n_s && arm_q;
  assign status = busy_q ? SR_BUSY_VAL :
    {arm_q, 3'h0, bp_q[1], bp_q[0], wen_q, 1'b0};

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 3'h0;
      rx_q <= 7'h00;
      op_q <= OP_NONE;
      addr_q <= 8'h00;
      sr_new_q <= 8'h00;
      sr_got_q <= 1'b0;
      tx_q <= SO_IDLE_VAL;
    end else if (cs_n_s) begin
      state_q <= ST_IDLE;
    end else if (cs_fall) begin
      state_q <= ST_CMD;
      bit_cnt_q <= 3'h0;
      op_q <= OP_NONE;
      sr_got_q <= 1'b0;
    end else if (sck_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      rx_q <= rx_byte[6:0];
      if (byte_done) begin
        unique case (state_q)
          ST_CMD: begin
            // While busy only the status read is honoured
            op_q <= (busy_q && rx_byte != OP_RDSR) ? OP_NONE : rx_byte;
            if (rx_byte == OP_RDSR) begin
              state_q <= ST_RDATA;
              tx_q <= status;
            end else if (busy_q) begin
              state_q <= ST_SKIP;
            end else if (is_read(rx_byte) || rx_byte == OP_WRITE || rx_byte == OP_IDWR) begin
              state_q <= ST_ADDR;
            end else if (rx_byte == OP_WRSR) begin
              state_q <= ST_WSR;
            end else begin
              state_q <= ST_SKIP;
            end
          end
          ST_ADDR: begin
            if (is_read(op_q)) begin
              state_q <= ST_RDATA;
              tx_q <= (op_q == OP_IDRD) ? idp_q[rx_byte[3:0]] : mem_q[rx_byte];
              addr_q <= rx_byte + 8'h01;
            end else begin
              state_q <= ST_WDATA;
              addr_q <= rx_byte;
            end
          end
          ST_WSR: begin
            sr_new_q <= rx_byte;
            sr_got_q <= 1'b1;
            state_q <= ST_SKIP;
          end
          ST_RDATA: begin
            if (op_q == OP_RDSR) begin
              tx_q <= status;
            end else begin
              tx_q <= (op_q == OP_IDRD) ? idp_q[addr_q[3:0]] : mem_q[addr_q];
              addr_q <= addr_q + 8'h01;
            end
          end
          ST_IDLE, ST_WDATA, ST_SKIP: begin
          end
          default: state_q <= ST_SKIP;
        endcase
      end
    end else if (sck_fall && state_q == ST_RDATA) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // Output bit changes on the falling edge; floats otherwise
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      so_q <= 1'b0;
      so_en_q <= 1'b0;
    end else begin
      if (sck_fall && state_q == ST_RDATA) so_q <= tx_q[7];
      so_en_q <= live && (state_q == ST_RDATA);
    end
  end
  assign so_o = so_q;
  assign so_oe_n_o = !so_en_q;

  // Incoming write bytes pass the buffer before the page latch
  assign in_if.valid = byte_done && (state_q == ST_WDATA);
  assign in_if.data = rx_byte;
  assign out_if.ready = !busy_q;

  sees_buf2 u_buf (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_s(in_if.snk),
    .out_s(out_if.src)
  );

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pl_mask_q <= '0;
      col_q <= '0;
      page_q <= 4'h0;
    end else if (cs_fall) begin
      pl_mask_q <= '0;
    end else if (byte_done && state_q == ST_ADDR) begin
      col_q <= rx_byte[3:0];
      page_q <= rx_byte[7:4];
    end else if (out_if.valid && out_if.ready) begin
      pl_mask_q[col_q] <= 1'b1;
      col_q <= col_q + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (out_if.valid && out_if.ready) pl_data_q[col_q] <= out_if.data;
  end

  // Commit waits until the buffer has drained into the latch
  assign commit_go = commit_pend_q && !out_if.valid;
  assign sr_go = cs_rise && op_q == OP_WRSR && sr_got_q && wen_q && !hw_prot;
  assign lk_go = cs_rise && op_q == OP_IDLK && wen_q && !lock_q;
  assign busy_start = commit_go || sr_go || lk_go;

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < PAGE_BYTES; i++) begin
      if (commit_go && pl_mask_q[i] && op_q == OP_WRITE && !blk_prot({page_q, 4'(i)}, bp_q)) begin
        mem_q[{page_q, 4'(i)}] <= pl_data_q[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < PAGE_BYTES; i++) begin
      if (commit_go && pl_mask_q[i] && op_q == OP_IDWR && !lock_q) begin
        idp_q[i] <= pl_data_q[i];
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      commit_pend_q <= 1'b0;
    end else if (commit_go) begin
      commit_pend_q <= 1'b0;
    end else if (cs_rise && (op_q == OP_WRITE || op_q == OP_IDWR) && wen_q && |pl_mask_q) begin
      commit_pend_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wen_q <= WEN_RST;
      bp_q <= BP_RST;
      arm_q <= ARM_RST;
      lock_q <= LOCK_RST;
    end else begin
      if (busy_start) wen_q <= 1'b0;
      else if (cs_rise && op_q == OP_WREN) wen_q <= 1'b1;
      else if (cs_rise && op_q == OP_WRDI) wen_q <= 1'b0;
      if (sr_go) begin
        bp_q <= {sr_new_q[SR_BP1_BIT], sr_new_q[SR_BP0_BIT]};
        arm_q <= sr_new_q[SR_ARM_BIT];
      end
      if (lk_go) lock_q <= 1'b1;
    end
  end

  // Self-timed cycle needs no serial clock
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_q <= 1'b0;
      busy_cnt_q <= '0;
    end else if (busy_start) begin
      busy_q <= 1'b1;
      busy_cnt_q <= BUSY_W'(WRITE_CYCLES - 1);
    end else if (busy_q) begin
      if (busy_cnt_q == '0) busy_q <= 1'b0;
      else busy_cnt_q <= busy_cnt_q - BUSY_W'(1);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) standby_o <= 1'b1;
    // Rising select is held out too, else standby blips before a pending write
    else standby_o <= cs_n_s && !cs_rise && !busy_q && !busy_start && !commit_pend_q;
  end
endmodule : sees_top
`default_nettype wire
